// >>> logic/lcdc_regs.svh
// constants of the lcd column driver instruction unit and its host controller
// What this block does
// RULE_01: D/I low: write is instruction, read is status
// RULE_02: D/I high: read or write display data
// RULE_03: opcodes: display_off_status_bit, start line, page, Y address
// RULE_04: on/off bit zero only, nothing else changes
// RULE_05: display off keeps RAM contents intact
// RULE_06: start line six bits, selects top row
// RULE_07: short duty shows consecutive lines from start
// RULE_08: page three bits forms upper RAM address
// RULE_09: page holds, never counts automatically
// RULE_10: set Y loads six-bit column counter
// RULE_11: Y advances after every data read/write
// RULE_12: Y wraps from 63 to 0
// RULE_13: write stores whole byte, bit 0 LSB
// RULE_14: read drives RAM byte then increments Y
// RULE_15: host discards first read after address set
// RULE_16: busy blocks all but status; host polls
// RULE_17: busy lasts one to three internal clocks
// RULE_18: status: busy bit7, off bit5, reset bit4
// RULE_19: off reads one; busy one while working
// RULE_20: reset bit set during init, status only
// RULE_21: host reconfigures everything after any reset
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define LCDC_OP_DISPLAY_OFF_STATUS_BIT       7'h1F
`define LCDC_OP_START       2'h3
`define LCDC_OP_PAGE        5'h17
`define LCDC_OP_YADDR       2'h1

// ----------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------
`define LCDC_ST_BUSY        7
`define LCDC_ST_OFF         5
`define LCDC_ST_RESET       4

// ----------------------------------------------------------------
// timing: internal clock period 1 us, busy two periods
// ----------------------------------------------------------------
`define LCDC_CLK_NS         8
`define LCDC_ICLK_NS        1000
`define LCDC_ICLK_CYC       (`LCDC_ICLK_NS / `LCDC_CLK_NS)
`define LCDC_BUSY_PERIODS   2
`define LCDC_INIT_PERIODS   4

// ----------------------------------------------------------------
// host controller apb map
// ----------------------------------------------------------------
`define LCDC_A_CMD          12'h000
`define LCDC_A_STAT         12'h004
`define LCDC_A_RDATA        12'h008
`define LCDC_CMD_GO         8
`define LCDC_CMD_DI         9
`define LCDC_CMD_RW         10
`define LCDC_MASK_OFF       12'hFF0
`define LCDC_BAD_ADDR       32'h0000_0000

`endif

// >>> logic/lcdc_pkg.sv
// types used by the host end of the lcd instruction link
package lcdc_pkg;
    typedef enum logic [1:0] {LCDC_IDLE, LCDC_WAIT, LCDC_DONE} lcdc_host_state_t;
    typedef logic [7:0] lcdc_byte_t;
endpackage

// >>> logic/lcdc_if.sv
// parallel microprocessor port between host controller and the driver
interface lcdc_if;
    logic       strobe;     // one-cycle access strobe, replaces the enable fall
    logic       di;         // 1 data, 0 instruction/status
    logic       rw;         // 1 read, 0 write
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;     // one-cycle pulse with rdata

    modport dev  (input strobe, input di, input rw, input wdata,
                  output rdata, output rvalid);
    modport host (output strobe, output di, output rw, output wdata,
                  input rdata, input rvalid);
endinterface

// >>> logic/lcdc_device.sv
// driver end: instruction decode, status, display ram and addressing
`include "lcdc_regs.svh"
module lcdc_device
    import lcdc_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst,
    lcdc_if.dev         bus,
    input  wire logic   [5:0] scan_line,
    input  wire logic   [5:0] panel_rows_m1,
    output logic        [5:0] display_line,
    output logic        [7:0] display_col,
    output logic        display_on
);
    logic [7:0]  ram [0:511];
    logic [2:0]  page;
    logic [5:0]  yaddr;
    logic [5:0]  start_line;
    logic [7:0]  out_reg;
    logic [11:0] busy_cnt;
    logic [11:0] init_cnt;
    logic        busy;
    logic        in_reset;
    logic        accept;
    logic        data_acc;
    logic [7:0]  status;

    assign busy     = busy_cnt != 12'h000;
    assign in_reset = init_cnt != 12'h000;
    // only status reads get through busy or init
    assign accept   = bus.strobe && !busy && !in_reset && !(!bus.di && bus.rw); // RULE_16 RULE_20
    assign data_acc = accept && bus.di; // RULE_02
    assign status   = {busy, 1'b0, !display_on, in_reset, 4'h0}; // RULE_18 RULE_19

    // ----------------------------------------------------------------
    // busy and init timers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst)
            busy_cnt <= 12'h000;
        else if (accept)
            busy_cnt <= 12'(`LCDC_BUSY_PERIODS * `LCDC_ICLK_CYC); // RULE_17
        else if (busy)
            busy_cnt <= busy_cnt - 12'h001;
    end

    always_ff @(posedge clock) begin
        if (rst)
            init_cnt <= 12'(`LCDC_INIT_PERIODS * `LCDC_ICLK_CYC); // RULE_20
        else if (in_reset)
            init_cnt <= init_cnt - 12'h001;
    end

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst)
            display_on <= 1'b0;
        else if (accept && !bus.di && !bus.rw && bus.wdata[7:1] == `LCDC_OP_DISPLAY_OFF_STATUS_BIT)
            display_on <= bus.wdata[0]; // RULE_01 RULE_03 RULE_04 RULE_05
    end

    always_ff @(posedge clock) begin
        if (rst)
            start_line <= 6'h00;
        else if (accept && !bus.di && !bus.rw && bus.wdata[7:6] == `LCDC_OP_START)
            start_line <= bus.wdata[5:0]; // RULE_06
    end

    // page and Y are undefined after reset in the part; zero here
    always_ff @(posedge clock) begin
        if (rst)
            page <= 3'h0;
        else if (accept && !bus.di && !bus.rw && bus.wdata[7:3] == `LCDC_OP_PAGE)
            page <= bus.wdata[2:0]; // RULE_08 RULE_09
    end

    always_ff @(posedge clock) begin
        if (rst)
            yaddr <= 6'h00;
        else if (accept && !bus.di && !bus.rw && bus.wdata[7:6] == `LCDC_OP_YADDR)
            yaddr <= bus.wdata[5:0]; // RULE_10
        else if (data_acc)
            yaddr <= yaddr + 6'h01; // RULE_11 RULE_12
    end

    // ----------------------------------------------------------------
    // display ram and output register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (data_acc && !bus.rw)
            ram[{page, yaddr}] <= bus.wdata; // RULE_13
    end

    // output register is reloaded only by a data read, so the first
    // read after an address set returns the previous contents
    always_ff @(posedge clock) begin
        if (rst)
            out_reg <= 8'h00;
        else if (data_acc && bus.rw)
            out_reg <= ram[{page, yaddr}]; // RULE_14 RULE_15
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bus.rdata  <= 8'h00;
            bus.rvalid <= 1'b0;
        end else begin
            bus.rvalid <= bus.strobe && bus.rw && (!bus.di || data_acc);
            if (bus.strobe && bus.rw)
                bus.rdata <= bus.di ? out_reg : status; // RULE_01 RULE_14
        end
    end

    // ----------------------------------------------------------------
    // refresh read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            display_line <= 6'h00;
            display_col  <= 8'h00;
        end else begin
            display_line <= 6'(start_line + (scan_line & panel_rows_m1)); // RULE_07
            display_col  <= display_on ? ram[{scan_line[5:3], scan_line[2:0], 3'h0}] : 8'h00;
        end
    end
endmodule // lcdc_device

// >>> logic/lcdc_host.sv
// host end: apb-commanded controller driving the parallel port
`include "lcdc_regs.svh"
module lcdc_host
    import lcdc_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst,
    lcdc_if.host        bus,
    input  wire logic   psel,
    input  wire logic   penable,
    input  wire logic   pwrite,
    input  wire logic   [11:0] paddr,
    input  wire logic   [31:0] pwdata,
    output logic        [31:0] prdata,
    output logic        pready,
    output logic        pslverr
);
    lcdc_host_state_t state;
    lcdc_byte_t       rbyte;
    logic             go;
    logic             is_read;

    assign pready  = 1'b1;
    assign go      = psel && penable && pwrite && paddr == `LCDC_A_CMD && pwdata[`LCDC_CMD_GO];
    assign pslverr = psel && penable && (paddr & `LCDC_MASK_OFF) != 12'h000;
    assign is_read = bus.rw;

    // ----------------------------------------------------------------
    // command sequencer; software polls status for busy itself
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state      <= LCDC_IDLE;
            bus.strobe <= 1'b0;
            bus.di     <= 1'b0;
            bus.rw     <= 1'b0;
            bus.wdata  <= 8'h00;
        end else begin
            bus.strobe <= 1'b0;
            case (state)
                LCDC_IDLE: begin
                    if (go) begin
                        bus.strobe <= 1'b1;
                        bus.di     <= pwdata[`LCDC_CMD_DI]; // RULE_01 RULE_02
                        bus.rw     <= pwdata[`LCDC_CMD_RW];
                        bus.wdata  <= pwdata[7:0];
                        state      <= pwdata[`LCDC_CMD_RW] ? LCDC_WAIT : LCDC_DONE;
                    end
                end
                LCDC_WAIT: begin
                    if (bus.rvalid)
                        state <= LCDC_IDLE;
                end
                LCDC_DONE: state <= LCDC_IDLE;
                default:   state <= LCDC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst)
            rbyte <= 8'h00;
        else if (bus.rvalid)
            rbyte <= bus.rdata; // RULE_15 RULE_16
    end

    always_comb begin
        prdata = `LCDC_BAD_ADDR;
        case (paddr)
            `LCDC_A_STAT:  prdata = {31'h0, state != LCDC_IDLE};
            `LCDC_A_RDATA: prdata = {24'h0, rbyte};
            `LCDC_A_CMD:   prdata = {21'h0, is_read, bus.di, 1'b0, bus.wdata};
            default:       prdata = `LCDC_BAD_ADDR;
        endcase
    end
endmodule // lcdc_host

// >>> tb/lcdc_link_checker.sv
// concurrent checks on the parallel link between host and driver
module lcdc_link_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       strobe,
    input wire logic       di,
    input wire logic       rw,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    int   op_age;
    int   rst_age;
    logic shown;
    logic st_rq;
    logic take;
    // ----------------------------------------------------------------
    // reference state
    // ----------------------------------------------------------------
    assign st_rq = strobe && !di && rw;
    // margins absorb the unknown phase of the internal clock
    assign take = strobe && !st_rq && op_age >= 240 && rst_age >= 490;
    always_ff @(posedge clock) begin
        if (rst) rst_age <= 0;
        else if (rst_age < 999) rst_age <= rst_age + 1;
    end
    always_ff @(posedge clock) begin
        if (rst) op_age <= 999;
        else if (take) op_age <= 0;
        else if (op_age < 999) op_age <= op_age + 1;
    end
    always_ff @(posedge clock) begin
        if (rst) shown <= 1'b0;
        else if (take && !di && !rw && wdata[7:1] == 7'h1F) shown <= wdata[0];
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_stat;
        st_rq;
    endsequence
    a_status_served: assert property (s_stat |=> rvalid)
        else $error("status read unanswered");
    a_data_served: assert property (take && di && rw |=> rvalid)
        else $error("data read unanswered");
    a_spare_zero: assert property (s_stat |=> (rdata & 8'h4F) == 8'h00)
        else $error("status spare bits set");
    a_off_bit: assert property (s_stat |=> rdata[5] == !$past(shown))
        else $error("status off bit wrong");
    a_busy_set: assert property (s_stat and op_age < 238 && rst_age > 512 |=> rdata[7])
        else $error("busy bit low too soon");
    a_busy_clear: assert property (s_stat and op_age > 262 && rst_age > 512 |=> !rdata[7])
        else $error("busy bit stuck");
    a_init_set: assert property (s_stat and rst_age < 488 |=> rdata[4])
        else $error("reset bit low during init");
    a_init_clear: assert property (s_stat and rst_age > 512 |=> !rdata[4])
        else $error("reset bit stuck");
    a_rvalid_cause: assert property (rvalid |-> $past(strobe && rw))
        else $error("read answer without read");
    a_strobe_single: assert property (strobe |=> !strobe)
        else $error("strobe longer than one cycle");
    a_rdata_hold: assert property (!rvalid && !$past(rst) |-> $stable(rdata))
        else $error("read data moved");
endmodule // lcdc_link_checker

// >>> tb/lcd_column_driver_instruction_unit_tb.sv
// self-checking bench: apb-driven host joined to the driver end
`include "lcdc_regs.svh"
module lcd_column_driver_instruction_unit_tb import lcdc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, display_on, mon, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [5:0]  scan_line, panel_rows_m1, display_line, start, my;
    logic [7:0]  display_col, mout;
    logic [2:0]  mpage;
    lcdc_byte_t  mram [0:511];
    int          n_fail, tests_run, seed, i;
    int          cycles = 0;
    lcdc_if link ();
    lcdc_device lcdc_device_inst (.clock(clock), .rst(rst), .bus(link),
        .scan_line(scan_line), .panel_rows_m1(panel_rows_m1),
        .display_line(display_line), .display_col(display_col), .display_on(display_on));
    lcdc_host lcdc_host_inst (.clock(clock), .rst(rst), .bus(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lcdc_link_checker chk (.clock(clock), .rst(rst), .strobe(link.strobe), .di(link.di),
        .rw(link.rw), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // a refused data read would leave the host waiting, so reads follow a ready poll
    task automatic xfer(input logic d_i, input logic r_w, input logic [7:0] b);
        apb(1'b1, `LCDC_A_CMD, {21'h0, r_w, d_i, 1'b1, b});
        do apb(1'b0, `LCDC_A_STAT, 32'h0); while (r[0] !== 1'b0);
        if (r_w) apb(1'b0, `LCDC_A_RDATA, 32'h0);
    endtask
    task automatic wait_ready();
        do xfer(1'b0, 1'b1, 8'h00); while (r[7] !== 1'b0 || r[4] !== 1'b0);
    endtask
    task automatic put(input logic d_i, input logic [7:0] b);
        xfer(d_i, 1'b0, b);
        if (d_i) begin
            mram[{mpage, my}] = b;
            my++;
        end
        else if (b[7:1] == 7'h1F) mon = b[0];
        else if (b[7:6] == 2'h3) start = b[5:0];
        else if (b[7:3] == 5'h17) mpage = b[2:0];
        else if (b[7:6] == 2'h1) my = b[5:0];
        wait_ready();
    endtask
    task automatic get(input logic chk_it);
        xfer(1'b1, 1'b1, 8'h00);
        if (chk_it) check("read data", mout, r[7:0]);
        mout = mram[{mpage, my}];
        my++;
        wait_ready();
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; scan_line = 6'h00; panel_rows_m1 = 6'h3F; seed = 32'hb73b;
        mon = 1'b0; mpage = 3'h0; my = 6'h00; start = 6'h00; n_fail = 0; tests_run = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        xfer(1'b0, 1'b1, 8'h00);
        check("reset bit", 1, r[4]);
        check("off bit", 1, r[5]);
        check("spare bits", 0, {r[6], r[3:0]});
        wait_ready();
        put(1'b0, {5'h17, 3'($random(seed))});
        put(1'b0, 8'h7E);
        for (i = 0; i < 3; i++) put(1'b1, 8'($random(seed)));
        xfer(1'b1, 1'b0, 8'hA5);
        mram[{mpage, my}] = 8'hA5;
        my++;
        xfer(1'b1, 1'b0, 8'h5A);
        wait_ready();
        put(1'b0, 8'h3F);
        check("display on", 1, display_on);
        put(1'b0, 8'h3E);
        check("display on", 0, display_on);
        check("dark column", 0, display_col);
        put(1'b0, 8'h3F);
        put(1'b0, {2'h3, 6'($random(seed))});
        for (i = 0; i < 4; i++) begin
            scan_line <= 6'($random(seed));
            repeat (4) @(posedge clock);
            check("display line", 6'(start + scan_line), display_line);
        end
        // half-height panel: only 32 consecutive lines from the start line
        panel_rows_m1 <= 6'h1F;
        for (i = 0; i < 3; i++) begin
            scan_line <= 6'($random(seed));
            repeat (4) @(posedge clock);
            check("short duty line", 6'(start + (scan_line & 6'h1F)), display_line);
        end
        panel_rows_m1 <= 6'h3F;
        put(1'b0, 8'h7E);
        get(1'b0);
        // fifth read shows whether the write sent while busy was refused
        for (i = 0; i < 5; i++) get(1'b1);
        apb(1'b0, 12'h010, 32'h0);
        check("slave error", 1, slv);
        apb(1'b0, `LCDC_A_STAT, 32'h0);
        check("slave error", 0, slv);
        // reset in mid-run: display off, init again, host must reconfigure
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        xfer(1'b0, 1'b1, 8'h00);
        check("reset bit", 1, r[4]);
        check("off bit", 1, r[5]);
        wait_ready();
        put(1'b0, 8'h3F);
        check("display on", 1, display_on);
        give_verdict();
    end
endmodule // lcd_column_driver_instruction_unit_tb
